/* File: kps_keypad_model.sv */
// Switch matrix model: thirty push switches at column-row crossings.
// Assumes rows pulled up; a closed switch ties its row to its column.
`timescale 1ns/1ps
module kps_keypad_model (
  // Column drive from the scanner
  input  wire logic [4:0]  col_out,
  // Closed switches, bit col*6+row
  input  wire logic [29:0] keys,
  // Row sense back to the scanner
  output logic      [5:0]  row_in
);
  // ------------------------------------------------------------
  // Row levels: pull-up unless a closed switch meets a low column
  // ------------------------------------------------------------
  always_comb begin
    row_in = 6'h3F;
    for (int c = 0; c < 5; c++) begin
      for (int r = 0; r < 6; r++) begin
        if (keys[c * 6 + r] && col_out[c] === 1'b0) begin
          row_in[r] = 1'b0;
        end
      end
    end
  end
endmodule : kps_keypad_model

/* File: kps_pkg.sv */
// Constants, field layout and state record of the keypad matrix scanner.
// Assumes a 50 MHz bus clock and byte-wide registers on AXI4-Lite words.
// Contract
// RL1 - Five column drive outputs and six row sense inputs, thirty keys.
// RL2 - Scanning is off after reset until firmware sets scan enable.
// RL3 - All scan and debounce timing comes from a 1 kHz tick.
// RL4 - Tick runs only while keypad clock enable bit 6 is set.
// RL5 - Rows and columns taking part are set by the dimension register.
// RL6 - Enabled and idle: all columns low, wait for any low row.
// RL7 - On a low row, wait one debounce period, confirm, then scan.
// RL8 - Debounce period is 4 ms to 256 ms in 4 ms steps.
// RL9 - No low row after debounce returns to idle, all columns low.
// RL10 - Scan drives one column low at a time, checks rows, moves on.
// RL11 - Two-bit scan time sets 1 to 4 ms between key checks.
// RL12 - Exactly one closed switch is a valid key; more report none.
// RL13 - Column order follows order registers; row order is fixed.
// RL14 - Firmware rewrites order registers whenever a new sequence is wanted.
// RL15 - Valid key stores column and row and raises the key interrupt.
// RL16 - While enabled, column and row results change only on valid keys.
// RL17 - Scanning continues without waiting for the interrupt to be serviced.
// RL18 - After any scan result, wait until the keys are released.
// RL19 - On release run debounce; restart if pressed, else go idle.
// RL20 - Scanning disabled: column outputs follow the column register.
// RL21 - Disabling mid-scan keeps the last stored column value on pins.
// RL22 - Bypass: firmware writes columns and reads rows itself.
// RL23 - Six-bit debounce field counts 4 ms; zero means 256 ms.
// RL24 - Key flag clears on status read; interrupt only when enabled.
// RL25 - Disabled: row falling edge after all high sets flag, tick or not.
// RL26 - Timers count ticks only and hold while the tick is stopped.
package kps_pkg;
  localparam int NUM_COLS = 5;
  localparam int NUM_ROWS = 6;
  localparam int ADDR_W   = 12;
  // Register word indices; byte address is four times the index
  localparam logic [9:0] IDX_COLRES = 10'h0D0;
  localparam logic [9:0] IDX_ROWRES = 10'h0D1;
  localparam logic [9:0] IDX_DIM    = 10'h0D2;
  localparam logic [9:0] IDX_TIMING = 10'h0D3;
  localparam logic [9:0] IDX_STATUS = 10'h0D4;
  localparam logic [9:0] IDX_ORD_LO = 10'h0D6;
  localparam logic [9:0] IDX_ORD_HI = 10'h0D7;
  localparam logic [9:0] IDX_MCLK   = 10'h0D8;
  // Reset values
  localparam logic [7:0] RST_TIMING = 8'h00;
  localparam logic [7:0] RST_ORD    = 8'h00;
  localparam logic [7:0] RST_DIM    = 8'h65;
  localparam logic [4:0] RST_COLRES = 5'h00;
  // Field positions
  localparam int BIT_IRQ_EN  = 0;
  localparam int BIT_FLAG    = 1;
  localparam int BIT_SCAN_EN = 2;
  localparam int BIT_KEYCLK  = 3;
  localparam int BIT_KB_EN   = 6;
  localparam int SC_LSB      = 0;
  localparam int DB_LSB      = 2;
  localparam int DIM_COL_LSB = 0;
  localparam int DIM_ROW_LSB = 4;
  // Timing
  localparam int CLK_HZ      = 50_000_000;
  localparam int TICK_HZ     = 1_000;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int DB_STEP_MS  = 4;
  localparam int DB_MAX_MS   = 256;
  localparam int SC_MAX_MS   = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    KPS_IDLE, KPS_PRESS_DB, KPS_SCAN, KPS_REL_WAIT, KPS_REL_DB
  } kps_phase_type;

  typedef struct packed {
    logic [5:0]  row_meta;
    logic [5:0]  row_sync;
    logic [5:0]  row_last;
    logic [15:0] tick_cnt;
    logic        tick_level;
    kps_phase_type phase;
    logic [8:0]  timer;
    logic [2:0]  step;
    logic [1:0]  hits;
    logic [2:0]  hit_col;
    logic [2:0]  hit_row;
    logic [4:0]  col_drive;
    logic [7:0]  timing;
    logic        scan_en;
    logic        irq_en;
    logic        flag;
    logic [4:0]  key_column_result;
    logic [5:0]  key_row_result;
    logic [7:0]  ord_lo;
    logic [6:0]  ord_hi;
    logic [7:0]  dim;
    logic        kb_en;
    logic        aw_held;
    logic [9:0]  aw_idx;
    logic        w_held;
    logic [7:0]  w_data;
    logic        w_en;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
  } kps_state_type;
endpackage : kps_pkg

/* File: kps_scanner.sv */
// Keypad matrix scanner with AXI4-Lite register slave.
// Assumes rows pulled up outside and asynchronous to aclk.
`timescale 1ns/1ps
module kps_scanner #(
  parameter int TICK_CYCLES = kps_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Keypad matrix
  output logic [4:0]       col_out,
  input  wire logic [5:0]  row_in,
  // Key interrupt
  output logic             key_irq
);

  kps_pkg::kps_state_type s;
  kps_pkg::kps_state_type n;
  logic       tick;
  logic [5:0] rmask;
  logic [5:0] pressed;
  logic       any_low;
  logic       flag_set;
  logic       rd_clear;
  logic [2:0] cur_col;
  logic       bypass_edge;

  //----------------------------------------
  // Helpers
  //----------------------------------------
  function automatic logic [8:0] db_ticks(input logic [7:0] t);
    logic [5:0] f;
    f = t[kps_pkg::DB_LSB +: 6];
    if (f == 6'h00) db_ticks = 9'(kps_pkg::DB_MAX_MS); // RL23
    else db_ticks = 9'(f * kps_pkg::DB_STEP_MS); // RL8
  endfunction : db_ticks

  function automatic logic [8:0] sc_ticks(input logic [7:0] t);
    logic [1:0] f;
    f = t[kps_pkg::SC_LSB +: 2];
    if (f == 2'h0) sc_ticks = 9'(kps_pkg::SC_MAX_MS); // RL11
    else sc_ticks = {7'h00, f};
  endfunction : sc_ticks

  function automatic logic [2:0] dim_cnt(input logic [2:0] v, input logic [2:0] max);
    if (v == 3'h0 || v > max) dim_cnt = max;
    else dim_cnt = v;
  endfunction : dim_cnt

  function automatic logic [2:0] order_col(input kps_pkg::kps_state_type st,
                                           input logic [2:0] idx);
    case (idx)
      3'h0:    order_col = st.ord_lo[2:0];
      3'h1:    order_col = st.ord_lo[5:3];
      3'h2:    order_col = {st.ord_hi[0], st.ord_lo[7:6]};
      3'h3:    order_col = st.ord_hi[3:1];
      default: order_col = st.ord_hi[6:4];
    endcase
  endfunction : order_col

  function automatic logic [1:0] pop2(input logic [5:0] v);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 0; i < 6; i++) c = c + {2'h0, v[i]};
    pop2 = (c > 3'h2) ? 2'h2 : c[1:0];
  endfunction : pop2

  function automatic logic [2:0] first_row(input logic [5:0] v);
    first_row = 3'h0;
    for (int i = 5; i >= 0; i--) if (v[i]) first_row = 3'(i);
  endfunction : first_row

  function automatic logic mapped(input logic [9:0] idx);
    mapped = idx inside {kps_pkg::IDX_COLRES, kps_pkg::IDX_ROWRES, kps_pkg::IDX_DIM,
                         kps_pkg::IDX_TIMING, kps_pkg::IDX_STATUS,
                         kps_pkg::IDX_ORD_LO, kps_pkg::IDX_ORD_HI, kps_pkg::IDX_MCLK};
  endfunction : mapped

  //----------------------------------------
  // Combinational views
  //----------------------------------------
  assign tick    = s.kb_en && s.tick_cnt == 16'(TICK_CYCLES - 1); // RL3 RL4
  assign rmask   = 6'(6'h3F >> (3'(kps_pkg::NUM_ROWS)
                   - dim_cnt(s.dim[kps_pkg::DIM_ROW_LSB +: 3], 3'(kps_pkg::NUM_ROWS)))); // RL5
  assign pressed = ~s.row_sync & rmask;
  assign any_low = |pressed;
  assign cur_col = order_col(s, s.step); // RL13
  assign bypass_edge = !s.scan_en && (&(s.row_last | ~rmask)) && any_low; // RL25
  assign rd_clear = arvalid && arready && araddr[11:2] == kps_pkg::IDX_STATUS;

  assign awready = !s.aw_held && !s.bvalid;
  assign wready  = !s.w_held && !s.bvalid;
  assign arready = !s.rvalid;
  assign bvalid  = s.bvalid;
  assign bresp   = s.bresp;
  assign rvalid  = s.rvalid;
  assign rdata   = {24'h000000, s.rdata};
  assign rresp   = s.rresp;
  assign col_out = s.col_drive; // RL1
  assign key_irq = s.flag && s.irq_en; // RL24 RL15

  //----------------------------------------
  // Next state
  //----------------------------------------
  always_comb begin
    logic [2:0] ncols;
    logic [1:0] cnt;
    logic [1:0] tot;
    logic [9:0] ri;
    ncols = dim_cnt(s.dim[kps_pkg::DIM_COL_LSB +: 3], 3'(kps_pkg::NUM_COLS));
    cnt = pop2(pressed);
    tot = 2'h0;
    ri = araddr[11:2];
    n = s;
    flag_set = 1'b0;
    n.row_meta = row_in;
    n.row_sync = s.row_meta;
    n.row_last = s.row_sync;
    if (s.kb_en) begin
      n.tick_cnt = tick ? 16'h0000 : s.tick_cnt + 16'h0001;
      if (tick) n.tick_level = ~s.tick_level;
    end
    // Scan sequencer; timers move on ticks only
    case (s.phase)
      kps_pkg::KPS_IDLE: begin
        if (s.scan_en && any_low) begin // RL6
          n.phase = kps_pkg::KPS_PRESS_DB;
          n.timer = db_ticks(s.timing);
        end
      end
      kps_pkg::KPS_PRESS_DB: begin
        if (tick) begin // RL26
          n.timer = s.timer - 9'h001;
          if (s.timer == 9'h001) begin
            if (any_low) begin // RL7
              n.phase = kps_pkg::KPS_SCAN;
              n.step  = 3'h0;
              n.hits  = 2'h0;
              n.timer = sc_ticks(s.timing);
            end else begin
              n.phase = kps_pkg::KPS_IDLE; // RL9
            end
          end
        end
      end
      kps_pkg::KPS_SCAN: begin
        if (tick) begin // RL11 RL26
          n.timer = s.timer - 9'h001;
          if (s.timer == 9'h001) begin
            tot = ({1'b0, s.hits} + {1'b0, cnt} > 3'h2) ? 2'h2 : 2'(s.hits + cnt); // RL12
            n.hits = tot;
            if (s.hits == 2'h0 && cnt != 2'h0) begin
              n.hit_col = cur_col;
              n.hit_row = first_row(pressed); // RL13
            end
            if (s.step == ncols - 3'h1) begin // RL10
              n.phase = kps_pkg::KPS_REL_WAIT; // RL18 RL17
              if (tot == 2'h1) begin // RL12 RL15 RL16
                n.key_column_result = 5'(~(5'h01 << (s.hits == 2'h0 ? cur_col : s.hit_col)));
                n.key_row_result = 6'(~(6'h01 << (s.hits == 2'h0 ? first_row(pressed)
                                                                 : s.hit_row)));
                flag_set = 1'b1;
              end
            end else begin
              n.step  = s.step + 3'h1;
              n.timer = sc_ticks(s.timing);
            end
          end
        end
      end
      kps_pkg::KPS_REL_WAIT: begin
        if (!any_low) begin // RL19
          n.phase = kps_pkg::KPS_REL_DB;
          n.timer = db_ticks(s.timing);
        end
      end
      kps_pkg::KPS_REL_DB: begin
        if (tick) begin // RL26
          n.timer = s.timer - 9'h001;
          if (s.timer == 9'h001) begin
            if (any_low) n.timer = db_ticks(s.timing); // RL19
            else n.phase = kps_pkg::KPS_IDLE;
          end
        end
      end
      default: n.phase = kps_pkg::KPS_IDLE;
    endcase
    if (bypass_edge) flag_set = 1'b1; // RL25
    // AXI write path
    if (awvalid && awready) begin
      n.aw_held = 1'b1;
      n.aw_idx  = awaddr[11:2];
    end
    if (wvalid && wready) begin
      n.w_held = 1'b1;
      n.w_data = wdata[7:0];
      n.w_en   = wstrb[0];
    end
    if (s.aw_held && s.w_held) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = mapped(s.aw_idx) ? kps_pkg::RESP_OKAY : kps_pkg::RESP_SLVERR;
      if (s.w_en) begin
        case (s.aw_idx)
          kps_pkg::IDX_TIMING: n.timing = s.w_data;
          kps_pkg::IDX_STATUS: begin
            n.scan_en = s.w_data[kps_pkg::BIT_SCAN_EN];
            n.irq_en  = s.w_data[kps_pkg::BIT_IRQ_EN];
          end
          kps_pkg::IDX_COLRES: if (!s.scan_en) n.key_column_result = s.w_data[4:0]; // RL16 RL22
          kps_pkg::IDX_ORD_LO: n.ord_lo = s.w_data; // RL14
          kps_pkg::IDX_ORD_HI: n.ord_hi = s.w_data[6:0];
          kps_pkg::IDX_DIM: n.dim = s.w_data;
          kps_pkg::IDX_MCLK: n.kb_en = s.w_data[kps_pkg::BIT_KB_EN];
          default: n.timing = s.timing;
        endcase
      end
    end
    if (s.bvalid && bready) n.bvalid = 1'b0;
    // AXI read path
    if (arvalid && arready) begin
      n.rvalid = 1'b1;
      n.rresp  = mapped(ri) ? kps_pkg::RESP_OKAY : kps_pkg::RESP_SLVERR;
      case (ri)
        kps_pkg::IDX_TIMING: n.rdata = s.timing;
        kps_pkg::IDX_STATUS: n.rdata = {4'h0, s.tick_level, s.scan_en, s.flag, s.irq_en};
        kps_pkg::IDX_COLRES: n.rdata = {3'h0, s.key_column_result};
        kps_pkg::IDX_ROWRES: n.rdata = {2'h0, s.scan_en ? s.key_row_result : s.row_sync}; // RL22
        kps_pkg::IDX_ORD_LO: n.rdata = s.ord_lo;
        kps_pkg::IDX_ORD_HI: n.rdata = {1'b0, s.ord_hi};
        kps_pkg::IDX_DIM:    n.rdata = s.dim;
        kps_pkg::IDX_MCLK:   n.rdata = {1'b0, s.kb_en, 6'h00};
        default:             n.rdata = 8'h00;
      endcase
    end
    if (s.rvalid && rready) n.rvalid = 1'b0;
    // Flag: a set in the clearing cycle wins
    n.flag = (s.flag && !rd_clear) || flag_set; // RL24
    if (!n.scan_en) n.phase = kps_pkg::KPS_IDLE; // RL21
    // Column pins follow the next state
    if (!n.scan_en) n.col_drive = n.key_column_result; // RL20 RL21
    else if (n.phase == kps_pkg::KPS_SCAN)
      n.col_drive = 5'(~(5'h01 << order_col(n, n.step))); // RL10
    else n.col_drive = 5'h00; // RL6
  end

  //----------------------------------------
  // State register
  //----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.row_meta <= 6'h3F;
      s.row_sync <= 6'h3F;
      s.row_last <= 6'h3F;
      s.phase    <= kps_pkg::KPS_IDLE;
      s.timing   <= kps_pkg::RST_TIMING;
      s.scan_en  <= 1'b0; // RL2
      s.key_column_result <= kps_pkg::RST_COLRES;
      s.col_drive <= kps_pkg::RST_COLRES;
      s.ord_lo   <= kps_pkg::RST_ORD;
      s.ord_hi   <= 7'(kps_pkg::RST_ORD);
      s.dim      <= kps_pkg::RST_DIM;
    end else begin
      s <= n;
    end
  end

  //----------------------------------------
  // Assertions
  //----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RESET_OFF: assert property ($rose(aresetn) |-> !s.scan_en && col_out == 5'h00) // RL2
    else $error("scan enabled after reset");
  AST_TICK_GATED: assert property (!s.kb_en |-> !tick) // RL4
    else $error("tick without clock enable");
  AST_IDLE_COLS: assert property (s.scan_en && s.phase != kps_pkg::KPS_SCAN
                                  |-> col_out == 5'h00) // RL6
    else $error("columns not all low outside scan");
  AST_ONE_COL: assert property (s.scan_en && s.phase == kps_pkg::KPS_SCAN
                                && cur_col < 3'h5 |-> $countones(~col_out) == 1) // RL10
    else $error("more than one column driven");
  AST_BYPASS_COLS: assert property (!s.scan_en |-> col_out == s.key_column_result) // RL20
    else $error("bypass columns differ from register");
  AST_RESULT_HOLD: assert property (s.scan_en && s.phase != kps_pkg::KPS_SCAN
                                    |=> $stable(s.key_column_result)
                                        && $stable(s.key_row_result)) // RL16
    else $error("result changed without valid key");
  AST_PRESS_FAIL: assert property (s.scan_en && s.phase == kps_pkg::KPS_PRESS_DB && tick
                                   && s.timer == 9'h001 && !any_low && n.scan_en
                                   |=> s.phase == kps_pkg::KPS_IDLE) // RL9
    else $error("no return to idle after bounce");
  AST_TIMER_HOLD: assert property (!tick && s.phase inside {kps_pkg::KPS_PRESS_DB,
                                   kps_pkg::KPS_SCAN, kps_pkg::KPS_REL_DB}
                                   |=> $stable(s.timer)) // RL26
    else $error("timer moved without tick");
  AST_IRQ_GATE: assert property (key_irq |-> s.irq_en && s.flag) // RL24
    else $error("interrupt without enabled flag");
  AST_READ_CLEAR: assert property (rd_clear && !flag_set |=> !s.flag) // RL24
    else $error("flag survived status read");
  AST_BYPASS_EDGE: assert property (bypass_edge |=> s.flag) // RL25
    else $error("row edge did not set flag");
  AST_REL_WAIT: assert property (s.phase == kps_pkg::KPS_REL_WAIT && any_low && n.scan_en
                                 |=> s.phase == kps_pkg::KPS_REL_WAIT) // RL18
    else $error("left release wait while pressed");

endmodule : kps_scanner

/* File: tb.sv */
// Self-checking bench for the keypad scanner: registers, bypass, scans.
// Assumes the switch matrix model and a shortened keypad tick.
`timescale 1ns/1ps
module tb;
  localparam int T = 10;
  logic        aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, key_irq;
  logic [1:0]  bresp, rresp;
  logic [4:0]  col_out;
  logic [5:0]  row_in;
  logic [29:0] keys;
  int          n_errors, num_checks;
  int          vis[8];

  kps_scanner #(.TICK_CYCLES(T)) uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .col_out(col_out), .row_in(row_in), .key_irq(key_irq)
  );
  kps_keypad_model pad (.col_out(col_out), .keys(keys), .row_in(row_in));

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : cyc

  function automatic logic [7:0] cpat(input int c);
    cpat = 8'h1F & ~(8'h01 << c);
  endfunction : cpat

  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw;
    @(posedge aclk);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, d};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    #1;
    while (awvalid || wvalid) begin
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      #1;
    end
    while (bvalid !== 1'b1) cyc(1);
    chk("bresp", er, bresp);
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [9:0] idx, input logic [7:0] e, input logic [7:0] m,
                      input logic [1:0] er, input string nm);
    @(posedge aclk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    #1;
    while (arready !== 1'b1) cyc(1);
    @(posedge aclk);
    arvalid <= 1'b0;
    #1;
    while (rvalid !== 1'b1) cyc(1);
    chk(nm, {er, e & m}, {rresp, rdata[7:0] & m});
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rchk

  // Follows the columns, noting scan start, visits and dwell of the second
  task automatic watch(input int lim, output int lat, output int nv, output int dw);
    logic [4:0] prev;
    int         t1, bad;
    prev = 5'h00;
    lat  = -1;
    nv   = 0;
    dw   = -1;
    t1   = 0;
    bad  = 0;
    for (int i = 0; i < lim; i++) begin
      cyc(1);
      if (col_out !== 5'h00 && !$onehot(~col_out)) bad++;
      if (col_out !== prev && $onehot(~col_out) && nv < 8) begin
        lat = (nv == 0) ? i : lat;
        dw  = (nv == 2) ? i - t1 : dw;
        t1  = i;
        for (int k = 0; k < 5; k++) begin
          if (col_out[k] === 1'b0) vis[nv] = k;
        end
        nv++;
      end
      prev = col_out;
    end
    chk("col_pattern", 0, bad);
  endtask : watch

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    cyc(1);
    chk("col_rst", 5'h00, col_out);
    chk("irq_rst", 0, key_irq);
    rchk(kps_pkg::IDX_TIMING, kps_pkg::RST_TIMING, 8'hFF, 2'h0, "timing");
    rchk(kps_pkg::IDX_STATUS, 8'h00, 8'hF7, 2'h0, "status");
    rchk(kps_pkg::IDX_COLRES, {3'h0, kps_pkg::RST_COLRES}, 8'hFF, 2'h0, "col_res");
    rchk(kps_pkg::IDX_ROWRES, 8'h3F, 8'hFF, 2'h0, "row_res");
    rchk(kps_pkg::IDX_DIM, kps_pkg::RST_DIM, 8'hFF, 2'h0, "dim");
    rchk(kps_pkg::IDX_ORD_LO, kps_pkg::RST_ORD, 8'hFF, 2'h0, "ord_lo");
    rchk(kps_pkg::IDX_ORD_HI, kps_pkg::RST_ORD, 8'hFF, 2'h0, "ord_hi");
    rchk(kps_pkg::IDX_MCLK, 8'h00, 8'hFF, 2'h0, "mclk");
    rchk(10'h0D5, 8'h00, 8'hFF, kps_pkg::RESP_SLVERR, "unmapped");
    wr(10'h0D5, 8'hFF, kps_pkg::RESP_SLVERR);
  endtask : t_reset

  task automatic t_bypass;
    wr(kps_pkg::IDX_COLRES, 8'h1E, 2'h0);
    cyc(2);
    chk("col_byp", 5'h1E, col_out);
    @(posedge aclk);
    keys <= 30'h1 << 4;
    cyc(4);
    rchk(kps_pkg::IDX_ROWRES, 8'h2F, 8'h3F, 2'h0, "row_live");
    chk("irq_masked", 0, key_irq);
    rchk(kps_pkg::IDX_STATUS, 8'h02, 8'h02, 2'h0, "flag_set");
    rchk(kps_pkg::IDX_STATUS, 8'h00, 8'h02, 2'h0, "flag_clr");
    wr(kps_pkg::IDX_STATUS, 8'h01, 2'h0);
    keys <= '0;
    cyc(4);
    @(posedge aclk);
    keys <= 30'h1 << 4;
    cyc(4);
    chk("irq_on", 1, key_irq);
    rchk(kps_pkg::IDX_STATUS, 8'h03, 8'h03, 2'h0, "flag_rd");
    keys <= '0;
    cyc(1);
    chk("irq_off", 0, key_irq);
  endtask : t_bypass

  task automatic t_scan;
    logic [7:0] tm[4] = '{8'h05, 8'h02, 8'h04, 8'h07};
    logic [2:0] nc[4] = '{3'd5, 3'd5, 3'd3, 3'd4};
    int         st[4] = '{0, 3, 2, 4};
    int         kr[4] = '{2, 5, 0, 3};
    int         lat, nv, dw, dbt, sct;
    int         c[5];
    wr(kps_pkg::IDX_MCLK, 8'h40, 2'h0);
    wr(kps_pkg::IDX_STATUS, 8'h05, 2'h0);
    cyc(4);
    chk("col_idle", 5'h00, col_out);
    for (int i = 0; i < 4; i++) begin
      dbt = (tm[i][7:2] == 0) ? 256 : 4 * tm[i][7:2];
      sct = (tm[i][1:0] == 0) ? 4 : tm[i][1:0];
      for (int k = 0; k < 5; k++) c[k] = (st[i] + 4 * k) % 5;
      wr(kps_pkg::IDX_TIMING, tm[i], 2'h0);
      wr(kps_pkg::IDX_ORD_LO, {c[2][1:0], c[1][2:0], c[0][2:0]}, 2'h0);
      wr(kps_pkg::IDX_ORD_HI, {1'b0, c[4][2:0], c[3][2:0], c[2][2]}, 2'h0);
      wr(kps_pkg::IDX_DIM, {4'h6, 1'b0, nc[i]}, 2'h0);
      @(posedge aclk);
      keys <= 30'h1 << (st[i] * 6 + kr[i]);
      watch((dbt + nc[i] * sct + 3) * T, lat, nv, dw);
      chk("lat_lo", 1, lat >= (dbt - 1) * T);
      chk("lat_hi", 1, lat <= (dbt + 1) * T + 5);
      chk("dwell", sct * T, dw);
      chk("visits", nc[i], nv);
      for (int k = 0; k < nc[i]; k++) chk("visit_col", c[k], vis[k]);
      chk("irq", 1, key_irq);
      rchk(kps_pkg::IDX_COLRES, cpat(st[i]), 8'h1F, 2'h0, "col_res");
      rchk(kps_pkg::IDX_ROWRES, 8'h3F & ~(8'h01 << kr[i]), 8'h3F, 2'h0, "row_res");
      if (i != 1) rchk(kps_pkg::IDX_STATUS, 8'h07, 8'h07, 2'h0, "status");
      keys <= '0;
      cyc((dbt + 3) * T);
      chk("col_rel", 5'h00, col_out);
    end
  endtask : t_scan

  task automatic t_two;
    int lat, nv, dw;
    wr(kps_pkg::IDX_TIMING, 8'h05, 2'h0);
    wr(kps_pkg::IDX_DIM, 8'h65, 2'h0);
    @(posedge aclk);
    keys <= (30'h1 << 1) | (30'h1 << 7);
    watch(12 * T, lat, nv, dw);
    chk("visits_two", 5, nv);
    rchk(kps_pkg::IDX_STATUS, 8'h00, 8'h02, 2'h0, "flag_two");
    rchk(kps_pkg::IDX_COLRES, cpat(4), 8'h1F, 2'h0, "col_keep");
    rchk(kps_pkg::IDX_ROWRES, 8'h37, 8'h3F, 2'h0, "row_keep");
    keys <= '0;
    cyc(2 * T);
    @(posedge aclk);
    keys <= 30'h1 << 7;
    watch(15 * T, lat, nv, dw);
    chk("visits_rel", 0, nv);
    @(posedge aclk);
    keys <= '0;
    cyc(10 * T);
  endtask : t_two

  task automatic t_bounce;
    int lat, nv, dw;
    @(posedge aclk);
    keys <= 30'h1 << 14;
    cyc(3);
    @(posedge aclk);
    keys <= '0;
    watch(8 * T, lat, nv, dw);
    chk("visits_bounce", 0, nv);
    rchk(kps_pkg::IDX_STATUS, 8'h00, 8'h02, 2'h0, "flag_bounce");
    wr(kps_pkg::IDX_DIM, 8'h35, 2'h0);
    @(posedge aclk);
    keys <= 30'h1 << 4;
    watch(8 * T, lat, nv, dw);
    chk("visits_masked", 0, nv);
    @(posedge aclk);
    keys <= '0;
    wr(kps_pkg::IDX_DIM, 8'h65, 2'h0);
  endtask : t_bounce

  task automatic t_gate;
    int lat, nv, dw;
    wr(kps_pkg::IDX_MCLK, 8'h00, 2'h0);
    @(posedge aclk);
    keys <= 30'h1 << 9;
    watch(20 * T, lat, nv, dw);
    chk("visits_off", 0, nv);
    wr(kps_pkg::IDX_MCLK, 8'h40, 2'h0);
    watch(12 * T, lat, nv, dw);
    chk("visits_on", 5, nv);
    rchk(kps_pkg::IDX_COLRES, cpat(1), 8'h1F, 2'h0, "col_gate");
    rchk(kps_pkg::IDX_STATUS, 8'h02, 8'h02, 2'h0, "flag_gate");
  endtask : t_gate

  task automatic t_mid;
    keys <= '0;
    cyc(8 * T);
    @(posedge aclk);
    keys <= 30'h1 << 18;
    cyc(1);
    while (!$onehot(~col_out)) cyc(1);
    wr(kps_pkg::IDX_STATUS, 8'h01, 2'h0);
    cyc(2);
    chk("col_hold", cpat(1), col_out);
    wr(kps_pkg::IDX_COLRES, 8'h15, 2'h0);
    cyc(2);
    chk("col_write", 5'h15, col_out);
    @(posedge aclk);
    keys <= '0;
  endtask : t_mid

  // ------------------------------------------------------------
  // Clock, sequence, verdict and watchdog
  // ------------------------------------------------------------
  task automatic wrap_up;
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    aresetn    = 1'b0;
    awaddr     = '0;
    awvalid    = 1'b0;
    wdata      = '0;
    wstrb      = '0;
    wvalid     = 1'b0;
    bready     = 1'b0;
    araddr     = '0;
    arvalid    = 1'b0;
    rready     = 1'b0;
    keys       = '0;
    n_errors   = 0;
    num_checks = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_bypass();
    t_scan();
    t_two();
    t_bounce();
    t_gate();
    t_mid();
    wrap_up();
  end

  initial begin
    #(60000 * 20);
    n_errors++;
    wrap_up();
  end
endmodule : tb
